//--- verilog/tsr_status_readback.sv
/*
  Status read-back and amplifier override register group of a narrowband radio
  transceiver, on a byte-wide register port with read data one cycle later.
  Assumes pin levels and analog comparators are asynchronous; all other inputs
  come from logic on ref_clk_i.
*/
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// Function
// - Override register holds three 2-bit stage fields, zero at reset, top bits reserved.
// - Calibration-done flag clears when calibration starts, sets when it finishes.
// - Sequencing fault flag sets when power-up sequence fails to lock.
// - Momentary lock bit shows lock detector state, unfiltered.
// - Qualified lock bit uses count selected by lock accuracy setting.
// - Carrier bit set while signal strength exceeds carrier threshold.
// - Three low flag bits show lock, data clock and data pin levels.
// - Reset-completion register gives eight subunit reset done flags.
// - Signal strength register gives 7-bit value in 1.5 dB steps.
// - Top bit of signal strength register always reads zero.
// - Frequency correction register gives signed 8-bit average deviation.
// - Shaping register gives signed 8-bit momentary frequency offset.
// - First test register gives calibration converter and pump current values.
// - Second test register gives version code and oscillator array value.
// - Third test register top bit shows frequency comparator output.
// - Third test register bit 6 shows oscillator calibration comparator.
// - Third test register low bits give oscillator calibration current.
// - Fourth test register gives mixer input and raw I and Q outputs.
module tsr_status_readback
  import tsr_pkg::*;
#(
  parameter logic [2:0] VERSION_CODE = 3'h5  // Arbitrary neutral value.
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rd_data_o,
  output logic      [1:0]        amp_stage1_override_o,
  output logic      [1:0]        amp_stage2_override_o,
  output logic      [1:0]        amp_stage3_override_o,
  output logic                   irq_o,
  input  wire logic              lock_pin_i,
  input  wire logic              data_clock_pin_i,
  input  wire logic              data_inout_pin_i,
  input  wire logic              lock_detect_i,
  input  wire logic              freq_comp_i,
  input  wire logic              osc_cal_comparator_i,
  input  wire logic              cal_start_i,
  input  wire logic              cal_finish_i,
  input  wire logic              seq_start_i,
  input  wire logic              seq_lock_fail_i,
  input  wire logic [1:0]        lock_accuracy_i,
  input  wire logic [6:0]        cs_level_i,
  input  wire logic [6:0]        signal_strength_i,
  input  wire logic [7:0]        afc_i,
  input  wire logic [7:0]        shaping_offset_value_i,
  input  wire logic [7:0]        reset_ok_i,
  input  wire logic [3:0]        cal_dac_i,
  input  wire logic [3:0]        pump_current_value_i,
  input  wire logic [4:0]        osc_array_value_i,
  input  wire logic [5:0]        osc_cal_current_value_i,
  input  wire logic [1:0]        adc_mix_i,
  input  wire logic [2:0]        adc_i_i,
  input  wire logic [2:0]        adc_q_i
);

  typedef struct packed {
    logic [AMP_OVR_W-1:0]  amp_ovr;
    logic                  cal_done;
    logic                  seq_fault;
    tsr_lock_t             lock_st;
    logic [LOCK_CNT_W-1:0] lock_cnt;
    logic                  carrier;
    logic [7:0]            reset_ok;
    logic [6:0]            signal_strength;
    logic [7:0]            afc;
    logic [7:0]            shaping;
    logic [7:0]            cal_pump;
    logic [4:0]            osc_array;
    logic [5:0]            osc_cur;
    logic [7:0]            conv_raw;
    logic [DATA_W-1:0]     rd_data;
  } tsr_core_st_t;

  tsr_core_st_t          q;
  tsr_core_st_t          d;
  logic [SYNC_W-1:0]     sync_lv;
  logic                  lock_now;
  logic [LOCK_CNT_W-1:0] lock_need;
  logic [7:0]            main_flags;
  logic [7:0]            rd_mux;
  tsr_irq_if             irq_bus ();

  // Pin levels and analog comparator outputs are asynchronous to this clock.
  tsr_sync #(
    .W (SYNC_W)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({osc_cal_comparator_i, freq_comp_i, lock_detect_i,
                 data_inout_pin_i, data_clock_pin_i, lock_pin_i}),
    .sync_o    (sync_lv)
  );

  // Sticky events, mask and the interrupt level.
  tsr_irq u_irq (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .irq_bus   (irq_bus.unit)
  );

  assign lock_now = sync_lv[SY_MOMLOCK];

  // Accuracy picks how long lock must hold.
  always_comb begin
    case (lock_accuracy_i)
      2'h0:    lock_need = LOCK_QUAL_CNT0;
      2'h1:    lock_need = LOCK_QUAL_CNT1;
      2'h2:    lock_need = LOCK_QUAL_CNT2;
      default: lock_need = LOCK_QUAL_CNT3;
    endcase
  end

  always_comb begin
    main_flags               = 8'h00;
    main_flags[MF_CAL_DONE]  = q.cal_done;
    main_flags[MF_SEQ_FAULT] = q.seq_fault;
    main_flags[MF_MOM_LOCK]  = lock_now;
    main_flags[MF_QUAL_LOCK] = (q.lock_st == TSR_LOCKED);
    main_flags[MF_CARRIER]   = q.carrier;
    main_flags[MF_LOCK_PIN]  = sync_lv[SY_LOCKPIN];
    main_flags[MF_DATA_CLK]  = sync_lv[SY_DATACLK];
    main_flags[MF_DATA_IO]   = sync_lv[SY_DATAIO];
  end

  // Read mux has no side effects; unmapped addresses read zero.
  always_comb begin
    case (addr_i)
      AMP_OVR_OFS:      rd_mux = {2'b00, q.amp_ovr};
      MAIN_FLAGS_OFS:   rd_mux = main_flags;
      RESET_FLAGS_OFS:  rd_mux = q.reset_ok;
      SIG_STRENGTH_OFS: rd_mux = {1'b0, q.signal_strength};
      FREQ_CORR_OFS:    rd_mux = q.afc;
      SHAPING_OFS:      rd_mux = q.shaping;
      CAL_PUMP_OFS:     rd_mux = q.cal_pump;
      VERSION_OSC_OFS:  rd_mux = {VERSION_CODE, q.osc_array};
      OSC_CAL_OFS:      rd_mux = {sync_lv[SY_FCOMP], sync_lv[SY_OSCCMP], q.osc_cur};
      CONV_RAW_OFS:     rd_mux = q.conv_raw;
      IRQ_STATUS_OFS:   rd_mux = {4'h0, irq_bus.status};
      IRQ_MASK_OFS:     rd_mux = {4'h0, irq_bus.mask};
      default:          rd_mux = RD_IDLE;
    endcase
  end

  // Software writes to the interrupt unit; other read-only addresses ignore writes.
  assign irq_bus.wr_status = wr_i && (addr_i == IRQ_STATUS_OFS);
  assign irq_bus.wr_mask   = wr_i && (addr_i == IRQ_MASK_OFS);
  assign irq_bus.wr_bits   = wr_data_i[IRQ_N-1:0];

  // Next state of the core.
  always_comb begin
    d = q;
    // Only the six override bits are stored.
    if (wr_i && (addr_i == AMP_OVR_OFS)) begin
      d.amp_ovr = wr_data_i[AMP_OVR_W-1:0];
    end
    // A new start wins over a finish in the same cycle.
    if (cal_start_i) begin
      d.cal_done = 1'b0;
    end else if (cal_finish_i) begin
      d.cal_done = 1'b1;
    end
    // A failure beats the clear of a new sequence.
    if (seq_lock_fail_i) begin
      d.seq_fault = 1'b1;
    end else if (seq_start_i) begin
      d.seq_fault = 1'b0;
    end
    // Qualified lock needs an unbroken run of momentary lock.
    case (q.lock_st)
      TSR_UNLOCKED: begin
        d.lock_cnt = '0;
        if (lock_now) begin
          d.lock_st = TSR_QUALIFYING;
        end
      end
      TSR_QUALIFYING: begin
        if (!lock_now) begin
          d.lock_st = TSR_UNLOCKED;
        end else if (q.lock_cnt >= lock_need - 7'h01) begin
          d.lock_st = TSR_LOCKED;
        end else begin
          d.lock_cnt = q.lock_cnt + 7'h01;
        end
      end
      TSR_LOCKED: begin
        if (!lock_now) begin
          d.lock_st = TSR_UNLOCKED;
        end
      end
      default: begin
        d.lock_st = TSR_UNLOCKED;
      end
    endcase
    d.carrier   = (signal_strength_i > cs_level_i);
    d.reset_ok  = reset_ok_i;
    d.signal_strength      = signal_strength_i;
    d.afc       = afc_i;
    d.shaping   = shaping_offset_value_i;
    // Converter value high, pump current low.
    d.cal_pump  = {cal_dac_i, pump_current_value_i};
    d.osc_array = osc_array_value_i;
    d.osc_cur   = osc_cal_current_value_i;
    // Mixer input, then I, then Q.
    d.conv_raw  = {adc_mix_i, adc_i_i, adc_q_i};
    // Read data stands only in the cycle after the strobe.
    d.rd_data   = rd_i ? rd_mux : RD_IDLE;
  end

  // Events compare next and present state so each fires once per change.
  always_comb begin
    irq_bus.event_pulse                = '0;
    irq_bus.event_pulse[IRQ_CAL_DONE]  = d.cal_done & ~q.cal_done;
    irq_bus.event_pulse[IRQ_SEQ_FAULT] = d.seq_fault & ~q.seq_fault;
    irq_bus.event_pulse[IRQ_CARRIER]   = d.carrier & ~q.carrier;
    irq_bus.event_pulse[IRQ_LOCK_LOST] = (q.lock_st == TSR_LOCKED) && (d.lock_st != TSR_LOCKED);
  end

  // State register.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q           <= '0;
      q.amp_ovr   <= AMP_OVR_RST;
      q.cal_done  <= CAL_DONE_RST;
      q.seq_fault <= SEQ_FAULT_RST;
      q.lock_st   <= TSR_UNLOCKED;
    end else begin
      q <= d;
    end
  end

  assign rd_data_o             = q.rd_data;
  assign amp_stage1_override_o = q.amp_ovr[AMP1_LSB+1:AMP1_LSB];
  assign amp_stage2_override_o = q.amp_ovr[AMP2_LSB+1:AMP2_LSB];
  assign amp_stage3_override_o = q.amp_ovr[AMP3_LSB+1:AMP3_LSB];
  assign irq_o                 = irq_bus.irq;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_amp_ovr_write: assert property (
    wr_i && (addr_i == AMP_OVR_OFS) |=> amp_stage1_override_o == $past(wr_data_i[5:4])
      && amp_stage2_override_o == $past(wr_data_i[3:2])
      && amp_stage3_override_o == $past(wr_data_i[1:0]))
    else $error("override write not stored");

  a_cal_clear: assert property (
    cal_start_i |=> !q.cal_done)
    else $error("cal done not cleared at start");

  a_cal_set: assert property (
    cal_finish_i && !cal_start_i |=> q.cal_done)
    else $error("cal done not set at finish");

  a_seq_fault_set: assert property (
    seq_lock_fail_i |=> q.seq_fault)
    else $error("sequencing fault not set");

  a_seq_fault_clear: assert property (
    seq_start_i && !seq_lock_fail_i |=> !q.seq_fault)
    else $error("sequencing fault not cleared");

  a_mom_lock_read: assert property (
    rd_i && (addr_i == MAIN_FLAGS_OFS) |=> rd_data_o[5] == $past(lock_now))
    else $error("momentary lock readback wrong");

  a_lock_drop: assert property (
    (q.lock_st == TSR_LOCKED) && !lock_now |=> q.lock_st == TSR_UNLOCKED)
    else $error("qualified lock kept without lock");

  a_lock_no_skip: assert property (
    (q.lock_st == TSR_UNLOCKED) |=> q.lock_st != TSR_LOCKED)
    else $error("qualified lock without qualifying run");

  a_carrier_cmp: assert property (
    signal_strength_i > cs_level_i |=> q.carrier)
    else $error("carrier not detected");

  a_carrier_low: assert property (
    signal_strength_i <= cs_level_i |=> !q.carrier)
    else $error("carrier set at or below threshold");

  a_pin_levels_read: assert property (
    rd_i && (addr_i == MAIN_FLAGS_OFS) |=> rd_data_o[2:0] == {$past(sync_lv[SY_LOCKPIN]),
      $past(sync_lv[SY_DATACLK]), $past(sync_lv[SY_DATAIO])})
    else $error("pin level readback wrong");

  a_reset_ok_read: assert property (
    rd_i && (addr_i == RESET_FLAGS_OFS) |=> rd_data_o == $past(q.reset_ok))
    else $error("reset flags readback wrong");

  a_signal_strength_snapshot: assert property (
    1'b1 |=> q.signal_strength == $past(signal_strength_i))
    else $error("signal strength not sampled");

  a_signal_strength_top_zero: assert property (
    rd_i && (addr_i == SIG_STRENGTH_OFS) |=> rd_data_o == {1'b0, $past(q.signal_strength)})
    else $error("signal strength readback wrong");

  a_freq_corr_read: assert property (
    rd_i && (addr_i == FREQ_CORR_OFS) |=> rd_data_o == $past(q.afc))
    else $error("frequency correction readback wrong");

  a_shaping_read: assert property (
    rd_i && (addr_i == SHAPING_OFS) |=> rd_data_o == $past(q.shaping))
    else $error("shaping offset readback wrong");

  a_cal_pump_read: assert property (
    rd_i && (addr_i == CAL_PUMP_OFS) |=> rd_data_o == $past(q.cal_pump))
    else $error("calibration and pump readback wrong");

  a_version_read: assert property (
    rd_i && (addr_i == VERSION_OSC_OFS) |=> rd_data_o == {VERSION_CODE, $past(q.osc_array)})
    else $error("version and array readback wrong");

  a_osc_cal_read: assert property (
    rd_i && (addr_i == OSC_CAL_OFS) |=> rd_data_o == {$past(sync_lv[SY_FCOMP]), $past(sync_lv[SY_OSCCMP]), $past(q.osc_cur)})
    else $error("oscillator calibration readback wrong");

  a_conv_raw_read: assert property (
    rd_i && (addr_i == CONV_RAW_OFS) |=> rd_data_o == $past(q.conv_raw))
    else $error("converter readback wrong");

  a_rd_idle: assert property (
    !rd_i |=> rd_data_o == RD_IDLE)
    else $error("read data outside read cycle");

  a_ro_write: assert property (
    wr_i && (addr_i == MAIN_FLAGS_OFS) && !cal_start_i && !cal_finish_i |=> q.cal_done == $past(q.cal_done))
    else $error("write changed read-only flag");

endmodule : tsr_status_readback

//--- shared/tsr_pkg.sv
/*
  Constants and types of the transceiver status read-back block: register offsets,
  field positions, reset values, interrupt bit layout and the lock qualifier counts.
  Assumes a byte-wide register port with an 8-bit address.
*/
package tsr_pkg;

  // Register port widths.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] AMP_OVR_OFS      = 8'h27;
  localparam logic [7:0] MAIN_FLAGS_OFS   = 8'h40;
  localparam logic [7:0] RESET_FLAGS_OFS  = 8'h41;
  localparam logic [7:0] SIG_STRENGTH_OFS = 8'h42;
  localparam logic [7:0] FREQ_CORR_OFS    = 8'h43;
  localparam logic [7:0] SHAPING_OFS      = 8'h44;
  localparam logic [7:0] CAL_PUMP_OFS     = 8'h45;
  localparam logic [7:0] VERSION_OSC_OFS  = 8'h46;
  localparam logic [7:0] OSC_CAL_OFS      = 8'h47;
  localparam logic [7:0] CONV_RAW_OFS     = 8'h48;
  localparam logic [7:0] IRQ_STATUS_OFS   = 8'h50;
  localparam logic [7:0] IRQ_MASK_OFS     = 8'h51;

  // Amplifier override fields and reset value.
  localparam int unsigned AMP_OVR_W   = 6;
  localparam int unsigned AMP1_LSB    = 4;
  localparam int unsigned AMP2_LSB    = 2;
  localparam int unsigned AMP3_LSB    = 0;
  localparam logic [5:0]  AMP_OVR_RST = 6'h00;

  // Main flag bit positions.
  localparam int unsigned MF_CAL_DONE   = 7;
  localparam int unsigned MF_SEQ_FAULT  = 6;
  localparam int unsigned MF_MOM_LOCK   = 5;
  localparam int unsigned MF_QUAL_LOCK  = 4;
  localparam int unsigned MF_CARRIER    = 3;
  localparam int unsigned MF_LOCK_PIN   = 2;
  localparam int unsigned MF_DATA_CLK   = 1;
  localparam int unsigned MF_DATA_IO    = 0;
  localparam logic        CAL_DONE_RST  = 1'b0;
  localparam logic        SEQ_FAULT_RST = 1'b0;

  // Positions inside the synchroniser vector.
  localparam int unsigned SYNC_W     = 6;
  localparam int unsigned SY_LOCKPIN = 0;
  localparam int unsigned SY_DATACLK = 1;
  localparam int unsigned SY_DATAIO  = 2;
  localparam int unsigned SY_MOMLOCK = 3;
  localparam int unsigned SY_FCOMP   = 4;
  localparam int unsigned SY_OSCCMP  = 5;

  // Interrupt layout and reset values.
  localparam int unsigned IRQ_N          = 4;
  localparam int unsigned IRQ_CAL_DONE   = 0;
  localparam int unsigned IRQ_SEQ_FAULT  = 1;
  localparam int unsigned IRQ_CARRIER    = 2;
  localparam int unsigned IRQ_LOCK_LOST  = 3;
  localparam logic [3:0]  IRQ_STATUS_RST = 4'h0;
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;

  // Consecutive momentary-lock cycles needed per lock accuracy setting.
  localparam int unsigned LOCK_CNT_W    = 7;
  localparam logic [6:0]  LOCK_QUAL_CNT0 = 7'h08;
  localparam logic [6:0]  LOCK_QUAL_CNT1 = 7'h10;
  localparam logic [6:0]  LOCK_QUAL_CNT2 = 7'h20;
  localparam logic [6:0]  LOCK_QUAL_CNT3 = 7'h40;

  // Read data when no read is answered.
  localparam logic [7:0]  RD_IDLE = 8'h00;

  typedef enum logic [1:0] {
    TSR_UNLOCKED   = 2'b00,
    TSR_QUALIFYING = 2'b01,
    TSR_LOCKED     = 2'b10
  } tsr_lock_t;

endpackage : tsr_pkg

//--- shared/tsr_irq_if.sv
/*
  Bundle between the read-back core and its interrupt unit: event pulses,
  software writes to the status and mask registers, and the readback.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface tsr_irq_if;
  import tsr_pkg::*;
  logic [IRQ_N-1:0] event_pulse;
  logic             wr_status;
  logic             wr_mask;
  logic [IRQ_N-1:0] wr_bits;
  logic [IRQ_N-1:0] status;
  logic [IRQ_N-1:0] mask;
  logic             irq;

  modport core (output event_pulse, output wr_status, output wr_mask, output wr_bits,
                input status, input mask, input irq);
  modport unit (input event_pulse, input wr_status, input wr_mask, input wr_bits,
                output status, output mask, output irq);
endinterface : tsr_irq_if

//--- verilog/tsr_sync.sv
/*
  Two flip-flop synchroniser for a vector of independent single-bit levels.
  Assumes each bit is unrelated to the others; words must not pass here.
*/
`timescale 1ns/1ps
module tsr_sync
  import tsr_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } tsr_sync_st_t;

  tsr_sync_st_t q;
  tsr_sync_st_t d;

  // The first stage feeds the second stage only, so metastability never fans out.
  always_comb begin
    d        = q;
    d.meta   = async_i;
    d.stable = q.meta;
  end

  // State register.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.stable;

endmodule : tsr_sync

//--- verilog/tsr_irq.sv
/*
  Interrupt unit: sticky event bits cleared by writing one, a mask of the same
  layout and one registered level interrupt. Assumes one-cycle event pulses.
*/
`timescale 1ns/1ps
module tsr_irq
  import tsr_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  tsr_irq_if.unit   irq_bus
);

  typedef struct packed {
    logic [IRQ_N-1:0] status;
    logic [IRQ_N-1:0] mask;
    logic             irq;
  } tsr_irq_st_t;

  tsr_irq_st_t q;
  tsr_irq_st_t d;

  // An event in the same cycle as its clear keeps the bit set, so nothing is lost.
  always_comb begin
    d = q;
    if (irq_bus.wr_status) begin
      d.status = q.status & ~irq_bus.wr_bits;
    end
    d.status = d.status | irq_bus.event_pulse;
    if (irq_bus.wr_mask) begin
      d.mask = irq_bus.wr_bits;
    end
    d.irq = |(d.status & d.mask);
  end

  // State register.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{status: IRQ_STATUS_RST, mask: IRQ_MASK_RST, irq: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign irq_bus.status = q.status;
  assign irq_bus.mask   = q.mask;
  assign irq_bus.irq    = q.irq;

endmodule : tsr_irq

//--- tb/tb_top.sv
/*
  Self-checking bench of the status read-back block: register port, flags,
  interrupts and random snapshot values.
  Assumes the package and the read-back top module are compiled before it.
*/
`timescale 1ns/1ps
module tb_top;
  import tsr_pkg::*;

  localparam logic [2:0] VER = 3'h3;  // Arbitrary version code.

  logic       ref_clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = '0, wr_data_i = '0, afc_i = '0, shaping_offset_value_i = '0, reset_ok_i = '0;
  logic       lock_pin_i = 1'b0, data_clock_pin_i = 1'b0, data_inout_pin_i = 1'b0, lock_detect_i = 1'b0;
  logic       freq_comp_i = 1'b0, osc_cal_comparator_i = 1'b0;
  logic       cal_start_i = 1'b0, cal_finish_i = 1'b0, seq_start_i = 1'b0, seq_lock_fail_i = 1'b0;
  logic [1:0] lock_accuracy_i = '0, adc_mix_i = '0;
  logic [6:0] cs_level_i = '0, signal_strength_i = '0;
  logic [3:0] cal_dac_i = '0, pump_current_value_i = '0;
  logic [4:0] osc_array_value_i = '0;
  logic [5:0] osc_cal_current_value_i = '0;
  logic [2:0] adc_i_i = '0, adc_q_i = '0;
  logic [7:0] rd_data_o, d;
  logic [1:0] o1, o2, o3;
  logic       irq_o;
  integer     seed = 56, v, n_mismatch = 0, tests_run = 0, cyc = 0;

  tsr_status_readback #(.VERSION_CODE(VER)) uut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .amp_stage1_override_o(o1),
    .amp_stage2_override_o(o2), .amp_stage3_override_o(o3), .irq_o(irq_o),
    .lock_pin_i(lock_pin_i), .data_clock_pin_i(data_clock_pin_i), .data_inout_pin_i(data_inout_pin_i),
    .lock_detect_i(lock_detect_i), .freq_comp_i(freq_comp_i), .osc_cal_comparator_i(osc_cal_comparator_i),
    .cal_start_i(cal_start_i), .cal_finish_i(cal_finish_i), .seq_start_i(seq_start_i),
    .seq_lock_fail_i(seq_lock_fail_i), .lock_accuracy_i(lock_accuracy_i), .cs_level_i(cs_level_i),
    .signal_strength_i(signal_strength_i), .afc_i(afc_i), .shaping_offset_value_i(shaping_offset_value_i),
    .reset_ok_i(reset_ok_i), .cal_dac_i(cal_dac_i), .pump_current_value_i(pump_current_value_i),
    .osc_array_value_i(osc_array_value_i), .osc_cal_current_value_i(osc_cal_current_value_i),
    .adc_mix_i(adc_mix_i), .adc_i_i(adc_i_i), .adc_q_i(adc_q_i));

  // Clock of 40 ns period.
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // A hang is cut short well past the few hundred cycles the run needs.
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One-cycle write; the settle delay lets registered outputs land.
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= dat;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  // Read data is taken in the one cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask : rd

  // Pulses {cal_start, cal_finish, seq_start, seq_lock_fail}, then lets the flags settle.
  task automatic ev(input logic [3:0] s);
    @(posedge ref_clk_i);
    {cal_start_i, cal_finish_i, seq_start_i, seq_lock_fail_i} <= s;
    @(posedge ref_clk_i);
    {cal_start_i, cal_finish_i, seq_start_i, seq_lock_fail_i} <= 4'h0;
    repeat (3) @(posedge ref_clk_i);
  endtask : ev

  // Expected read value from the bench's own copy of the inputs.
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    case (a)
      8'h40: exp_reg = {2'b00, lock_detect_i, 2'b00, lock_pin_i, data_clock_pin_i, data_inout_pin_i};
      8'h41: exp_reg = reset_ok_i;
      8'h42: exp_reg = {1'b0, signal_strength_i};
      8'h43: exp_reg = afc_i;
      8'h44: exp_reg = shaping_offset_value_i;
      8'h45: exp_reg = {cal_dac_i, pump_current_value_i};
      8'h46: exp_reg = {VER, osc_array_value_i};
      8'h47: exp_reg = {freq_comp_i, osc_cal_comparator_i, osc_cal_current_value_i};
      default: exp_reg = {adc_mix_i, adc_i_i, adc_q_i};
    endcase
  endfunction : exp_reg

  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd(8'h27);
    chk("ovr_rst", {2'b00, o1, o2, o3}, 8'h00);
    chk("ovr_rst_rd", d, 8'h00);
    chk("irq_rst", {7'h00, irq_o}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h3F : $random(seed);
      // software keeps the reserved top bits at zero.
      wr(8'h27, {2'b00, v[5:0]});
      chk("ovr_out", {2'b00, o1, o2, o3}, {2'b00, v[5:0]});
      rd(8'h27);
      chk("ovr_rd", d, {2'b00, v[5:0]});
    end
    // read-only and unmapped writes change nothing.
    for (int a = 8'h40; a <= 8'h48; a++) wr(a[7:0], 8'hFF);
    wr(8'h30, 8'hFF);
    rd(8'h27);
    chk("ovr_keep", d, {2'b00, v[5:0]});
    rd(8'h30);
    chk("unmapped", d, 8'h00);
    // random snapshots of every read-back register.
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_i);
      v = $random(seed);
      {lock_pin_i, data_clock_pin_i, data_inout_pin_i, lock_detect_i, freq_comp_i, osc_cal_comparator_i} <= v[5:0];
      {reset_ok_i, afc_i, shaping_offset_value_i} <= 24'($random(seed));
      {signal_strength_i, cal_dac_i, pump_current_value_i, osc_array_value_i, osc_cal_current_value_i} <= 26'($random(seed));
      {adc_mix_i, adc_i_i, adc_q_i} <= v[15:8];
      repeat (4) @(posedge ref_clk_i);
      rd(8'h40);
      chk("main_pins", d & 8'h27, exp_reg(8'h40));
      for (int a = 8'h41; a <= 8'h48; a++) begin
        rd(a[7:0]);
        chk("readback", d, exp_reg(a[7:0]));
      end
    end
    wr(8'h50, 8'h0F);
    wr(8'h51, 8'h00);
    @(posedge ref_clk_i);
    lock_detect_i <= 1'b0;
    cs_level_i <= 7'h10;
    signal_strength_i <= 7'h10;
    repeat (4) @(posedge ref_clk_i);
    // calibration flag, start wins over finish.
    ev(4'hC);
    rd(8'h40);
    chk("cal_both", {7'h00, d[7]}, 8'h00);
    ev(4'h4);
    rd(8'h40);
    chk("cal_done", {7'h00, d[7]}, 8'h01);
    ev(4'h8);
    rd(8'h40);
    chk("cal_start", {7'h00, d[7]}, 8'h00);
    ev(4'h4);
    ev(4'h1);
    rd(8'h40);
    chk("seq_fault", {7'h00, d[6]}, 8'h01);
    ev(4'h2);
    rd(8'h40);
    chk("seq_clear", {7'h00, d[6]}, 8'h00);
    ev(4'h3);
    rd(8'h40);
    chk("seq_both", {7'h00, d[6]}, 8'h01);
    rd(8'h40);
    chk("carrier_eq", {7'h00, d[3]}, 8'h00);
    @(posedge ref_clk_i);
    signal_strength_i <= 7'h11;
    repeat (3) @(posedge ref_clk_i);
    rd(8'h40);
    chk("carrier_gt", {7'h00, d[3]}, 8'h01);
    // qualify counts of 8 and 64 cycles.
    @(posedge ref_clk_i);
    lock_detect_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd(8'h40);
    chk("qual_early", {6'h00, d[5:4]}, 8'h02);
    repeat (20) @(posedge ref_clk_i);
    rd(8'h40);
    chk("qual_8", {7'h00, d[4]}, 8'h01);
    @(posedge ref_clk_i);
    lock_detect_i <= 1'b0;
    lock_accuracy_i <= 2'h3;
    repeat (4) @(posedge ref_clk_i);
    lock_detect_i <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    rd(8'h40);
    chk("qual_64_early", {7'h00, d[4]}, 8'h00);
    repeat (40) @(posedge ref_clk_i);
    rd(8'h40);
    chk("qual_64", {7'h00, d[4]}, 8'h01);
    // the middle accuracy settings need 16 and 32 cycles.
    for (int k = 1; k < 3; k++) begin
      @(posedge ref_clk_i);
      lock_detect_i <= 1'b0;
      lock_accuracy_i <= k[1:0];
      repeat (4) @(posedge ref_clk_i);
      lock_detect_i <= 1'b1;
      repeat (4 << k) @(posedge ref_clk_i);
      rd(8'h40);
      chk("qual_mid_early", {7'h00, d[4]}, 8'h00);
      repeat (8 << k) @(posedge ref_clk_i);
      rd(8'h40);
      chk("qual_mid", {7'h00, d[4]}, 8'h01);
    end
    // Interrupt status, mask and write-one clear.
    rd(8'h50);
    chk("irq_stat", d, 8'h0F);
    rd(8'h50);
    chk("irq_stat_again", d, 8'h0F);
    chk("irq_masked", {7'h00, irq_o}, 8'h00);
    for (int b = 0; b < 4; b++) begin
      wr(8'h51, 8'h01 << b);
      chk("irq_on", {7'h00, irq_o}, 8'h01);
      wr(8'h50, 8'h01 << b);
      chk("irq_off", {7'h00, irq_o}, 8'h00);
    end
    rd(8'h50);
    chk("irq_clear", d, 8'h00);
    rd(8'h51);
    chk("irq_mask", d, 8'h08);
    summarize();
  end
endmodule : tb_top
